// *** shared/bsre_map.svh ***
// constants of the branch, skip and rotate execution block
`ifndef BSRE_MAP_SVH
`define BSRE_MAP_SVH

// program counter and pointer widths
`define BSRE_PC_W        22
`define BSRE_PTR_W       16
`define BSRE_UPPER_LSB   16

// status register bit positions
`define BSRE_FLAG_C      3'h0
`define BSRE_FLAG_Z      3'h1
`define BSRE_FLAG_N      3'h2
`define BSRE_FLAG_V      3'h3
`define BSRE_FLAG_S      3'h4
`define BSRE_FLAG_H      3'h5
`define BSRE_FLAG_T      3'h6
`define BSRE_FLAG_I      3'h7

// reset values
`define BSRE_RST_PC      22'h00_0000
`define BSRE_RST_BYTE    8'h00
`define BSRE_RST_CYC     3'h0

// cycle counts
`define BSRE_CYC_ONE     3'h1
`define BSRE_CYC_JUMP    3'h2
`define BSRE_CYC_CALL_S  3'h3
`define BSRE_CYC_CALL_L  3'h4
`define BSRE_CYC_SKIP1   3'h2
`define BSRE_CYC_SKIP2   3'h3
`define BSRE_CYC_TAKEN   3'h2

// program counter steps
`define BSRE_STEP_NEXT   22'h00_0001
`define BSRE_STEP_SKIP1  22'h00_0002
`define BSRE_STEP_SKIP2  22'h00_0003

`endif

// *** shared/bsre_pkg.sv ***
// types of the branch, skip and rotate execution block
package bsre_pkg;

    typedef enum logic [4:0] {
        BSRE_POINTER_JUMP              = 5'h00,
        BSRE_POINTER_CALL              = 5'h01,
        BSRE_COMPARE_SKIP_EQUAL        = 5'h02,
        BSRE_SKIP_REG_BIT_CLEAR        = 5'h03,
        BSRE_SKIP_REG_BIT_SET          = 5'h04,
        BSRE_SKIP_IO_BIT_CLEAR         = 5'h05,
        BSRE_SKIP_IO_BIT_SET           = 5'h06,
        BSRE_BRANCH_FLAG_SET           = 5'h07,
        BSRE_BRANCH_FLAG_CLEAR         = 5'h08,
        BSRE_BRANCH_SIGNED_GE          = 5'h09,
        BSRE_BRANCH_SIGNED_LT          = 5'h0A,
        BSRE_BRANCH_UNSIGNED_GE        = 5'h0B,
        BSRE_BRANCH_UNSIGNED_LT        = 5'h0C,
        BSRE_BRANCH_HALF_CARRY_SET     = 5'h0D,
        BSRE_BRANCH_HALF_CARRY_CLEAR   = 5'h0E,
        BSRE_BRANCH_TRANSFER_BIT_SET   = 5'h0F,
        BSRE_BRANCH_TRANSFER_BIT_CLEAR = 5'h10,
        BSRE_BRANCH_OVERFLOW_SET       = 5'h11,
        BSRE_BRANCH_OVERFLOW_CLEAR     = 5'h12,
        BSRE_BRANCH_IRQ_ENABLED        = 5'h13,
        BSRE_BRANCH_IRQ_DISABLED       = 5'h14,
        BSRE_ROTATE_LEFT_CARRY         = 5'h15,
        BSRE_ROTATE_RIGHT_CARRY        = 5'h16
    } bsre_op_t;

    typedef enum logic [1:0] {
        BSRE_IDLE = 2'b01,
        BSRE_BUSY = 2'b10
    } bsre_state_t;

endpackage

// *** logic/bsre_bit_test.sv ***
// selected bit of a byte compared against a wanted level
`timescale 1ns/1ns
module bsre_bit_test (
    input  wire logic [7:0] value_i,
    input  wire logic [2:0] index_i,
    input  wire logic       want_one_i,
    output logic            hit_o
);
    assign hit_o = (value_i[index_i] == want_one_i);
endmodule

// *** logic/bsre_exec.sv ***
// execution unit for pointer jumps, skips, flag branches and rotates
`timescale 1ns/1ns
`include "bsre_map.svh"
// Function
// - pointer jump loads pc low bits from third pointer, clears upper bits, two cycles
// - pointer call pushes return address, loads pointer, clears upper, three or four cycles
// - compare skip skips next when operands equal, pc plus two or three
// - register bit clear skip skips when selected bit is zero, flags untouched
// - register bit set skip skips when selected bit is one, flags untouched
// - io bit clear skip skips when io bit reads zero, one to three cycles
// - io bit set skip skips when io bit reads one, one to three cycles
// - branch on flag set adds offset plus one when status bit is one
// - branch on flag clear adds offset plus one when status bit is zero
// - signed greater or equal branch taken when negative xor overflow is zero
// - signed less than branch taken when negative xor overflow is one
// - unsigned same or higher taken on carry zero, lower on carry one
// - half carry branches taken on half carry one for set, zero for clear
// - transfer bit branches taken on transfer flag zero for clear, one for set
// - overflow branches taken on overflow one for set, zero for clear
// - interrupt enabled branch taken when global enable is one
// - interrupt disabled branch taken when global enable is zero
// - rotate left through carry, updates z c n v h, one cycle
// - rotate right through carry, updates z c n v, one cycle
module bsre_exec (
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    start_i,
    input  wire bsre_pkg::bsre_op_t      op_i,
    input  wire logic [2:0]              bit_sel_i,
    input  wire logic [6:0]              offset_i,
    input  wire logic [7:0]              rd_data_i,
    input  wire logic [7:0]              rr_data_i,
    input  wire logic [7:0]              io_data_i,
    input  wire logic [7:0]              status_register_i,
    input  wire logic [15:0]             z_ptr_i,
    input  wire logic [21:0]             pc_i,
    input  wire logic                    next_two_word_i,
    output logic                         busy_o,
    output logic                         done_o,
    output logic [2:0]                   cycles_o,
    output logic                         taken_o,
    output logic [21:0]                  pc_o,
    output logic                         push_o,
    output logic [21:0]                  ret_addr_o,
    output logic [7:0]                   result_o,
    output logic                         result_we_o,
    output logic [7:0]                   status_register_o,
    output logic                         status_register_we_o
);
    import bsre_pkg::*;

    bsre_state_t  state_ff;
    logic [2:0]   cnt_ff;
    logic         accept;
    logic         reg_hit;
    logic         io_hit;
    logic         flag_hit;
    logic         reg_want;
    logic         io_want;
    logic [2:0]   br_idx;
    logic         br_want;
    logic         is_cond_br;
    logic         signed_lt;
    logic [21:0]  k_ext;
    logic [21:0]  skip_step;
    logic [2:0]   skip_cyc;
    logic [21:0]  nxt_pc;
    logic [2:0]   nxt_cycles;
    logic         nxt_taken;
    logic         nxt_push;
    logic [7:0]   nxt_result;
    logic         nxt_result_we;
    logic [7:0]   nxt_status_register;
    logic         nxt_status_register_we;
    logic [7:0]   rot;

    assign accept    = start_i && (state_ff == BSRE_IDLE);
    assign k_ext     = {{15{offset_i[6]}}, offset_i};
    assign signed_lt = status_register_i[`BSRE_FLAG_N] ^ status_register_i[`BSRE_FLAG_V];
    // skipped instruction length sets both step and cost
    assign skip_step = next_two_word_i ? `BSRE_STEP_SKIP2 : `BSRE_STEP_SKIP1;
    assign skip_cyc  = next_two_word_i ? `BSRE_CYC_SKIP2 : `BSRE_CYC_SKIP1;
    assign reg_want  = (op_i == BSRE_SKIP_REG_BIT_SET);
    assign io_want   = (op_i == BSRE_SKIP_IO_BIT_SET);

    bsre_bit_test u_reg_bit (
        .value_i    (rr_data_i),
        .index_i    (bit_sel_i),
        .want_one_i (reg_want),
        .hit_o      (reg_hit)
    );

    bsre_bit_test u_io_bit (
        .value_i    (io_data_i),
        .index_i    (bit_sel_i),
        .want_one_i (io_want),
        .hit_o      (io_hit)
    );

    bsre_bit_test u_flag_bit (
        .value_i    (status_register_i),
        .index_i    (br_idx),
        .want_one_i (br_want),
        .hit_o      (flag_hit)
    );

    // status bit and level tested by each single-flag branch
    always_comb begin
        br_idx     = bit_sel_i;
        br_want    = 1'b1;
        is_cond_br = 1'b1;
        unique case (op_i)
            BSRE_BRANCH_FLAG_SET: begin
                br_want = 1'b1;
            end
            BSRE_BRANCH_FLAG_CLEAR: begin
                br_want = 1'b0;
            end
            BSRE_BRANCH_UNSIGNED_GE: begin
                br_idx  = `BSRE_FLAG_C;
                br_want = 1'b0;
            end
            BSRE_BRANCH_UNSIGNED_LT: begin
                br_idx  = `BSRE_FLAG_C;
                br_want = 1'b1;
            end
            BSRE_BRANCH_HALF_CARRY_SET: begin
                br_idx  = `BSRE_FLAG_H;
                br_want = 1'b1;
            end
            BSRE_BRANCH_HALF_CARRY_CLEAR: begin
                br_idx  = `BSRE_FLAG_H;
                br_want = 1'b0;
            end
            BSRE_BRANCH_TRANSFER_BIT_SET: begin
                br_idx  = `BSRE_FLAG_T;
                br_want = 1'b1;
            end
            BSRE_BRANCH_TRANSFER_BIT_CLEAR: begin
                br_idx  = `BSRE_FLAG_T;
                br_want = 1'b0;
            end
            BSRE_BRANCH_OVERFLOW_SET: begin
                br_idx  = `BSRE_FLAG_V;
                br_want = 1'b1;
            end
            BSRE_BRANCH_OVERFLOW_CLEAR: begin
                br_idx  = `BSRE_FLAG_V;
                br_want = 1'b0;
            end
            BSRE_BRANCH_IRQ_ENABLED: begin
                br_idx  = `BSRE_FLAG_I;
                br_want = 1'b1;
            end
            BSRE_BRANCH_IRQ_DISABLED: begin
                br_idx  = `BSRE_FLAG_I;
                br_want = 1'b0;
            end
            default: begin
                is_cond_br = 1'b0;
            end
        endcase
    end

    // next pc, cost and data results of the offered instruction
    always_comb begin
        nxt_pc        = pc_i + `BSRE_STEP_NEXT;
        nxt_cycles    = `BSRE_CYC_ONE;
        nxt_taken     = 1'b0;
        nxt_push      = 1'b0;
        nxt_result    = rd_data_i;
        nxt_result_we = 1'b0;
        nxt_status_register      = status_register_i;
        nxt_status_register_we   = 1'b0;
        rot           = rd_data_i;
        unique case (op_i)
            BSRE_POINTER_JUMP: begin
                nxt_pc     = {6'h00, z_ptr_i};
                nxt_cycles = `BSRE_CYC_JUMP;
                nxt_taken  = 1'b1;
            end
            BSRE_POINTER_CALL: begin
                nxt_pc     = {6'h00, z_ptr_i};
                nxt_push   = 1'b1;
                nxt_taken  = 1'b1;
                nxt_cycles = (pc_i[21:16] == 6'h00) ? `BSRE_CYC_CALL_S : `BSRE_CYC_CALL_L;
            end
            BSRE_COMPARE_SKIP_EQUAL: begin
                if (rd_data_i == rr_data_i) begin
                    nxt_pc     = pc_i + skip_step;
                    nxt_cycles = skip_cyc;
                    nxt_taken  = 1'b1;
                end
            end
            BSRE_SKIP_REG_BIT_CLEAR, BSRE_SKIP_REG_BIT_SET: begin
                if (reg_hit) begin
                    nxt_pc     = pc_i + skip_step;
                    nxt_cycles = skip_cyc;
                    nxt_taken  = 1'b1;
                end
            end
            BSRE_SKIP_IO_BIT_CLEAR, BSRE_SKIP_IO_BIT_SET: begin
                if (io_hit) begin
                    nxt_pc     = pc_i + skip_step;
                    nxt_cycles = skip_cyc;
                    nxt_taken  = 1'b1;
                end
            end
            BSRE_BRANCH_SIGNED_GE, BSRE_BRANCH_SIGNED_LT: begin
                if (signed_lt == (op_i == BSRE_BRANCH_SIGNED_LT)) begin
                    nxt_pc     = pc_i + k_ext + `BSRE_STEP_NEXT;
                    nxt_cycles = `BSRE_CYC_TAKEN;
                    nxt_taken  = 1'b1;
                end
            end
            BSRE_ROTATE_LEFT_CARRY: begin
                rot                     = {rd_data_i[6:0], status_register_i[`BSRE_FLAG_C]};
                nxt_result              = rot;
                nxt_result_we           = 1'b1;
                nxt_status_register_we             = 1'b1;
                nxt_status_register[`BSRE_FLAG_C]  = rd_data_i[7];
                nxt_status_register[`BSRE_FLAG_Z]  = (rot == 8'h00);
                nxt_status_register[`BSRE_FLAG_N]  = rot[7];
                nxt_status_register[`BSRE_FLAG_V]  = rot[7] ^ rd_data_i[7];
                nxt_status_register[`BSRE_FLAG_H]  = rd_data_i[3];
            end
            BSRE_ROTATE_RIGHT_CARRY: begin
                rot                     = {status_register_i[`BSRE_FLAG_C], rd_data_i[7:1]};
                nxt_result              = rot;
                nxt_result_we           = 1'b1;
                nxt_status_register_we             = 1'b1;
                nxt_status_register[`BSRE_FLAG_C]  = rd_data_i[0];
                nxt_status_register[`BSRE_FLAG_Z]  = (rot == 8'h00);
                nxt_status_register[`BSRE_FLAG_N]  = rot[7];
                nxt_status_register[`BSRE_FLAG_V]  = rot[7] ^ rd_data_i[0];
            end
            default: begin
                if (is_cond_br && flag_hit) begin
                    nxt_pc     = pc_i + k_ext + `BSRE_STEP_NEXT;
                    nxt_cycles = `BSRE_CYC_TAKEN;
                    nxt_taken  = 1'b1;
                end
            end
        endcase
    end

    // sequencing: busy for the instruction's cycle count, done in its last
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_ff <= BSRE_IDLE;
            cnt_ff   <= `BSRE_RST_CYC;
            busy_o   <= 1'b0;
            done_o   <= 1'b0;
        end else begin
            unique case (state_ff)
                BSRE_IDLE: begin
                    done_o <= 1'b0;
                    if (accept) begin
                        state_ff <= BSRE_BUSY;
                        cnt_ff   <= nxt_cycles;
                        busy_o   <= 1'b1;
                        done_o   <= (nxt_cycles == `BSRE_CYC_ONE);
                    end
                end
                BSRE_BUSY: begin
                    cnt_ff <= cnt_ff - 3'h1;
                    done_o <= (cnt_ff == 3'h2);
                    if (cnt_ff == `BSRE_CYC_ONE) begin
                        state_ff <= BSRE_IDLE;
                        busy_o   <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= BSRE_IDLE;
                    busy_o   <= 1'b0;
                    done_o   <= 1'b0;
                end
            endcase
        end
    end

    // results latched at acceptance and held until the next one
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cycles_o    <= `BSRE_RST_CYC;
            taken_o     <= 1'b0;
            pc_o        <= `BSRE_RST_PC;
            ret_addr_o  <= `BSRE_RST_PC;
            result_o    <= `BSRE_RST_BYTE;
            result_we_o <= 1'b0;
            status_register_o      <= `BSRE_RST_BYTE;
            status_register_we_o   <= 1'b0;
        end else if (accept) begin
            cycles_o    <= nxt_cycles;
            taken_o     <= nxt_taken;
            pc_o        <= nxt_pc;
            ret_addr_o  <= pc_i + `BSRE_STEP_NEXT;
            result_o    <= nxt_result;
            result_we_o <= nxt_result_we;
            status_register_o      <= nxt_status_register;
            status_register_we_o   <= nxt_status_register_we;
        end
    end

    // stack push request, one cycle after a call is accepted
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            push_o <= 1'b0;
        end else begin
            push_o <= accept && nxt_push;
        end
    end

    property p_ptr_jump;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_POINTER_JUMP) |=> busy_o && !done_o ##1
            done_o && pc_o == {6'h00, $past(z_ptr_i, 2)};
    endproperty
    a_ptr_jump: assert property (p_ptr_jump) else $error("pointer jump pc or timing wrong");

    property p_ptr_call;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_POINTER_CALL && pc_i[21:16] == 6'h00) |=>
            push_o && ret_addr_o == $past(pc_i) + 22'h00_0001 && pc_o[21:16] == 6'h00 ##2 done_o;
    endproperty
    a_ptr_call: assert property (p_ptr_call) else $error("pointer call push or timing wrong");

    property p_cmp_skip;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_COMPARE_SKIP_EQUAL && rd_data_i == rr_data_i && !next_two_word_i) |=>
            pc_o == $past(pc_i) + 22'h00_0002 && cycles_o == 3'h2;
    endproperty
    a_cmp_skip: assert property (p_cmp_skip) else $error("compare skip step wrong");

    property p_reg_clr;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_SKIP_REG_BIT_CLEAR) |=>
            taken_o == !$past(rr_data_i[bit_sel_i]) && !status_register_we_o;
    endproperty
    a_reg_clr: assert property (p_reg_clr) else $error("register bit clear skip wrong");

    property p_reg_set;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_SKIP_REG_BIT_SET) |=>
            taken_o == $past(rr_data_i[bit_sel_i]) && !status_register_we_o;
    endproperty
    a_reg_set: assert property (p_reg_set) else $error("register bit set skip wrong");

    property p_io_set_long;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_SKIP_IO_BIT_SET && io_data_i[bit_sel_i] && next_two_word_i) |=>
            !done_o ##1 !done_o ##1 done_o ##1 !busy_o;
    endproperty
    a_io_set_long: assert property (p_io_set_long) else $error("io skip over long word timing wrong");

    property p_branch_set;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_BRANCH_FLAG_SET && status_register_i[bit_sel_i]) |=>
            pc_o == $past(pc_i) + {{15{$past(offset_i[6])}}, $past(offset_i)} + 22'h00_0001 && cycles_o == 3'h2;
    endproperty
    a_branch_set: assert property (p_branch_set) else $error("flag set branch target wrong");

    property p_signed_ge;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_BRANCH_SIGNED_GE) |=>
            taken_o == !($past(status_register_i[2]) ^ $past(status_register_i[3]));
    endproperty
    a_signed_ge: assert property (p_signed_ge) else $error("signed ge condition wrong");

    property p_rotate_left;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_ROTATE_LEFT_CARRY) |=>
            result_o == {$past(rd_data_i[6:0]), $past(status_register_i[0])} && status_register_o[0] == $past(rd_data_i[7]) && done_o;
    endproperty
    a_rotate_left: assert property (p_rotate_left) else $error("rotate left result wrong");

    property p_rotate_right;
        @(posedge clock_i) disable iff (rst_i)
        (accept && op_i == BSRE_ROTATE_RIGHT_CARRY) |=>
            result_o == {$past(status_register_i[0]), $past(rd_data_i[7:1])} && status_register_o[5] == $past(status_register_i[5]);
    endproperty
    a_rotate_right: assert property (p_rotate_right) else $error("rotate right result wrong");

    c_call: cover property (@(posedge clock_i) disable iff (rst_i) accept && op_i == BSRE_POINTER_CALL);
    c_skip2: cover property (@(posedge clock_i) disable iff (rst_i) accept && nxt_cycles == 3'h3);
    c_branch: cover property (@(posedge clock_i) disable iff (rst_i) accept && is_cond_br && flag_hit);
    c_rotate: cover property (@(posedge clock_i) disable iff (rst_i) accept && op_i == BSRE_ROTATE_RIGHT_CARRY);
endmodule

// *** tb/testbench.sv ***
// self-checking bench of the branch, skip and rotate execution unit
`timescale 1ns/1ns
module testbench;
    import bsre_pkg::*;
    logic             clock_i         = 1'b0;
    logic             rst_i           = 1'b1;
    logic             start_i         = 1'b0;
    bsre_op_t         op_i            = BSRE_POINTER_JUMP;
    logic [2:0]       bit_sel_i       = 3'h0;
    logic [6:0]       offset_i        = 7'h00;
    logic [7:0]       rd_data_i       = 8'h00;
    logic [7:0]       rr_data_i       = 8'h00;
    logic [7:0]       io_data_i       = 8'h00;
    logic [7:0]       status_register_i          = 8'h00;
    logic [15:0]      z_ptr_i         = 16'h0000;
    logic [21:0]      pc_i            = 22'h00_0000;
    logic             next_two_word_i = 1'b0;
    logic             busy_o, done_o, taken_o, push_o, result_we_o, status_register_we_o;
    logic [2:0]       cycles_o;
    logic [21:0]      pc_o, ret_addr_o;
    logic [7:0]       result_o, status_register_o;
    logic [21:0]      e_pc;
    logic [2:0]       e_cyc;
    logic [7:0]       e_res, e_status_register;
    logic             e_tk, e_rot;
    int               fail_count = 0;
    int               tests_run  = 0;
    int               cyc_count  = 0;

    bsre_exec dut (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i), .bit_sel_i(bit_sel_i),
        .offset_i(offset_i), .rd_data_i(rd_data_i), .rr_data_i(rr_data_i), .io_data_i(io_data_i),
        .status_register_i(status_register_i), .z_ptr_i(z_ptr_i), .pc_i(pc_i), .next_two_word_i(next_two_word_i),
        .busy_o(busy_o), .done_o(done_o), .cycles_o(cycles_o), .taken_o(taken_o), .pc_o(pc_o),
        .push_o(push_o), .ret_addr_o(ret_addr_o), .result_o(result_o), .result_we_o(result_we_o),
        .status_register_o(status_register_o), .status_register_we_o(status_register_we_o));

    always #50 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 3000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // two operand sets per operation, chosen so every condition is seen both ways
    task automatic load(input bsre_op_t op, input logic v);
        op_i = op;
        bit_sel_i = v ? 3'h7 : 3'h1;
        offset_i = v ? 7'h7e : 7'h05;
        rd_data_i = v ? 8'h96 : 8'h00;
        rr_data_i = v ? 8'h96 : 8'h69;
        io_data_i = v ? 8'h69 : 8'h96;
        status_register_i = v ? 8'hfb : 8'h00;
        z_ptr_i = v ? 16'hbe5a : 16'h1234;
        pc_i = v ? 22'h15_0010 : 22'h00_0100;
        next_two_word_i = v;
    endtask

    task automatic model();
        logic [2:0] b;
        logic [7:0] s;
        b = bit_sel_i;
        s = status_register_i;
        e_rot = op_i inside {BSRE_ROTATE_LEFT_CARRY, BSRE_ROTATE_RIGHT_CARRY};
        case (op_i)
            BSRE_POINTER_JUMP, BSRE_POINTER_CALL: e_tk = 1'b1;
            BSRE_COMPARE_SKIP_EQUAL:        e_tk = rd_data_i == rr_data_i;
            BSRE_SKIP_REG_BIT_CLEAR:        e_tk = !rr_data_i[b];
            BSRE_SKIP_REG_BIT_SET:          e_tk = rr_data_i[b];
            BSRE_SKIP_IO_BIT_CLEAR:         e_tk = !io_data_i[b];
            BSRE_SKIP_IO_BIT_SET:           e_tk = io_data_i[b];
            BSRE_BRANCH_FLAG_SET:           e_tk = s[b];
            BSRE_BRANCH_FLAG_CLEAR:         e_tk = !s[b];
            BSRE_BRANCH_SIGNED_GE:          e_tk = !(s[2] ^ s[3]);
            BSRE_BRANCH_SIGNED_LT:          e_tk = s[2] ^ s[3];
            BSRE_BRANCH_UNSIGNED_GE:        e_tk = !s[0];
            BSRE_BRANCH_UNSIGNED_LT:        e_tk = s[0];
            BSRE_BRANCH_HALF_CARRY_SET:     e_tk = s[5];
            BSRE_BRANCH_HALF_CARRY_CLEAR:   e_tk = !s[5];
            BSRE_BRANCH_TRANSFER_BIT_SET:   e_tk = s[6];
            BSRE_BRANCH_TRANSFER_BIT_CLEAR: e_tk = !s[6];
            BSRE_BRANCH_OVERFLOW_SET:       e_tk = s[3];
            BSRE_BRANCH_OVERFLOW_CLEAR:     e_tk = !s[3];
            BSRE_BRANCH_IRQ_ENABLED:        e_tk = s[7];
            BSRE_BRANCH_IRQ_DISABLED:       e_tk = !s[7];
            default:                        e_tk = 1'b0;
        endcase
        e_pc = pc_i + 22'h00_0001;
        e_cyc = 3'h1;
        if (op_i == BSRE_POINTER_JUMP || op_i == BSRE_POINTER_CALL) begin
            e_pc = {6'h00, z_ptr_i};
            e_cyc = (op_i == BSRE_POINTER_JUMP) ? 3'h2 : ((pc_i[21:16] == 6'h00) ? 3'h3 : 3'h4);
        end else if (op_i <= BSRE_SKIP_IO_BIT_SET) begin
            if (e_tk) begin
                e_pc = pc_i + (next_two_word_i ? 22'h00_0003 : 22'h00_0002);
                e_cyc = next_two_word_i ? 3'h3 : 3'h2;
            end
        end else if (!e_rot && e_tk) begin
            e_pc = pc_i + {{15{offset_i[6]}}, offset_i} + 22'h00_0001;
            e_cyc = 3'h2;
        end
        e_status_register = s;
        if (e_rot) begin
            e_res = (op_i == BSRE_ROTATE_LEFT_CARRY) ? {rd_data_i[6:0], s[0]} : {s[0], rd_data_i[7:1]};
            e_status_register[0] = (op_i == BSRE_ROTATE_LEFT_CARRY) ? rd_data_i[7] : rd_data_i[0];
            e_status_register[1] = e_res == 8'h00;
            e_status_register[2] = e_res[7];
            e_status_register[3] = e_res[7] ^ e_status_register[0];
            if (op_i == BSRE_ROTATE_LEFT_CARRY) e_status_register[5] = rd_data_i[3];
        end
    endtask

    // issue one instruction at a falling edge; poke offers a rotate while busy
    task automatic run(input logic poke);
        int n;
        int d;
        bsre_op_t o;
        model();
        o = op_i;
        n = 0;
        d = 0;
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        chk(push_o, o == BSRE_POINTER_CALL);
        chk(ret_addr_o, pc_i + 22'h00_0001);
        chk(cycles_o, e_cyc);
        chk(taken_o, e_tk);
        chk(status_register_o, e_status_register);
        chk(status_register_we_o, e_rot);
        chk(result_we_o, e_rot);
        if (e_rot) chk(result_o, e_res);
        while (busy_o === 1'b1 && n < 8) begin
            n++;
            if (done_o === 1'b1) d = n;
            start_i = poke && n == 1;
            if (poke) op_i = BSRE_ROTATE_LEFT_CARRY;
            @(negedge clock_i);
        end
        start_i = 1'b0;
        chk(22'(n), e_cyc);
        chk(22'(d), e_cyc);
        chk(pc_o, e_pc);
        $display("test of operation %0d finished", o);
    endtask

    initial begin
        repeat (20) @(negedge clock_i);
        chk({busy_o, done_o, taken_o, push_o, status_register_we_o, result_we_o}, 22'h00_0000);
        chk(pc_o, 22'h00_0000);
        rst_i = 1'b0;
        for (int o = 0; o <= 22; o++) begin
            for (int v = 0; v < 2; v++) begin
                load(bsre_op_t'(o), v[0]);
                run(1'b0);
            end
        end
        // offer during a long call is ignored
        load(BSRE_POINTER_CALL, 1'b1);
        run(1'b1);
        // reset in mid-jump, then a rotate straight after
        load(BSRE_POINTER_JUMP, 1'b1);
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        rst_i = 1'b1;
        @(negedge clock_i);
        chk({busy_o, done_o, taken_o}, 22'h00_0000);
        chk(pc_o, 22'h00_0000);
        rst_i = 1'b0;
        load(BSRE_ROTATE_RIGHT_CARRY, 1'b1);
        run(1'b0);
        final_report();
    end
endmodule
